/* bench/ciu_core_model.sv */
// behavioural cpu core that takes interrupt cycles from the unit
`timescale 1ns/100ps
module ciu_core_model
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic int_req_i,
  input wire logic [2:0] int_src_i,
  input wire logic [15:0] int_vec_i,
  input wire logic [1:0] delay_i,
  output logic int_ack_o,
  output logic taken_o,
  output logic [2:0] taken_src_o,
  output logic [15:0] taken_vec_o
);
  logic [1:0] wait_ff;
  ////////////////////////////////////////////////////////////////////////
  // ack after delay_i idle cycles, held until sampled together with the request or until the request drops
  always @(posedge clock_i)
  begin
    taken_o <= 1'b0;
    if (!rst_b_i)
    begin
      int_ack_o <= 1'b0;
      wait_ff <= 2'h0;
    end
    else if (int_ack_o && int_req_i)
    begin
      // interrupt cycle: a real core pushes state and fetches bytes 2n, 2n+1 here
      taken_o <= 1'b1;
      taken_src_o <= int_src_i;
      taken_vec_o <= int_vec_i;
      int_ack_o <= 1'b0;
      wait_ff <= 2'h0;
    end
    else if (!int_req_i)
      int_ack_o <= 1'b0; // request withdrawn: an ack now would be ignored anyway
    else if (wait_ff >= delay_i)
      int_ack_o <= 1'b1;
    else
      wait_ff <= wait_ff + 2'h1;
  end
endmodule

/* bench/tb_ciu_top.sv */
// self-checking bench of the interrupt and timer unit
`timescale 1ns/100ps
`include "ciu_regs.svh"
module tb_ciu_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] pv = 8'h3f;
  logic dsp_n = 1'b1;
  logic ack, req, tk;
  logic rd_tk = 1'b0;
  logic [2:0] src, tk_src, e_src;
  logic [15:0] vec, tk_vec;
  logic [1:0] dly = 2'h0;
  logic [7:0] rd_q[$];
  logic [2:0] int_q[$];
  logic [7:0] tog [6] = '{8'h80, 8'h40, 8'h08, 8'h10, 8'h20, 8'h04};
  logic [7:0] res [6] = '{8'h01, 8'h04, 8'h01, 8'h02, 8'h04, 8'h02};
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  // pin vector: {cmp2, cmp1, hs2, hs1, hs0, c, b, a}
  ciu_top i_dut
  (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .edge_pin_a_i(pv[0]), .edge_pin_b_i(pv[1]), .falling_pin_c_i(pv[2]),
    .hs0_data_valid_n_i(pv[3]), .hs1_data_valid_n_i(pv[4]), .hs2_data_valid_n_i(pv[5]),
    .comparator_one_out_i(pv[6]), .comparator_two_out_i(pv[7]), .dsp_req_n_i(dsp_n),
    .int_ack_i(ack), .int_req_o(req), .int_src_o(src), .int_vec_addr_o(vec)
  );
  ciu_core_model i_core
  (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .int_req_i(req), .int_src_i(src),
    .int_vec_i(vec), .delay_i(dly), .int_ack_o(ack), .taken_o(tk),
    .taken_src_o(tk_src), .taken_vec_o(tk_vec)
  );
  ////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial
  begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // strobes drop at the next falling edge, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clock_i);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(negedge clock_i);
    addr = a;
    rd_s = 1'b1;
    @(negedge clock_i);
    rd_s = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic grant_wait;
    int n;
    n = 0;
    while (int_q.size() != 0 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    if (int_q.size() != 0)
    begin
      failures++;
      int_q.delete();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // remember which edges took a read
  always @(posedge clock_i)
    rd_tk <= rd_s;
  // compare each result as it appears against the oldest note
  always @(negedge clock_i)
  begin
    if (rd_tk)
      check({8'h00, rdata}, {8'h00, rd_q.pop_front()});
    if (tk)
    begin
      e_src = int_q.pop_front();
      check({13'h0, tk_src}, {13'h0, e_src});
      check(tk_vec, {12'h000, e_src, 1'b0});
    end
  end
  // hang guard: the run needs far fewer cycles than this
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int m, d, l, s;
    void'($urandom(75341));
    idle(5);
    rst_b_i = 1'b1;
    idle(2);
    rd(`CIU_OFS_FLAGS, 8'h00);
    rd(`CIU_OFS_MASK, 8'h00);
    rd(8'h80, 8'h00);
    // every edge code, falling then rising on pins a and b
    for (int c = 0; c < 4; c++)
    begin
      wr(`CIU_OFS_FLAGS, {c[1:0], 6'h00});
      pv = 8'h3c;
      idle(6);
      rd(`CIU_OFS_FLAGS, {c[1:0], 3'h0, c != 2, 1'b0, c != 1});
      rd(`CIU_OFS_PINS, 8'h04);
      wr(`CIU_OFS_FLAGS, {c[1:0], 6'h00});
      pv = 8'h3f;
      idle(6);
      rd(`CIU_OFS_FLAGS, {c[1:0], 3'h0, c[1], 1'b0, c[0]});
      rd(`CIU_OFS_PINS, 8'h07);
    end
    // comparators, handshakes and pin c; the return edge must not set a flag
    for (int i = 0; i < 6; i++)
    begin
      wr(`CIU_OFS_FLAGS, 8'h00);
      pv = 8'h3f ^ tog[i];
      idle(6);
      rd(`CIU_OFS_FLAGS, res[i]);
      wr(`CIU_OFS_FLAGS, 8'h00);
      pv = 8'h3f;
      idle(6);
      rd(`CIU_OFS_FLAGS, 8'h00);
    end
    // coprocessor request and its clear bit
    wr(`CIU_OFS_FLAGS, 8'h00);
    dsp_n = 1'b0; // coprocessor raises its request
    idle(3);
    rd(`CIU_OFS_COPROC, 8'h01);
    rd(`CIU_OFS_FLAGS, 8'h08);
    dsp_n = 1'b1;
    wr(`CIU_OFS_COPROC, 8'h00);
    rd(`CIU_OFS_COPROC, 8'h01);
    wr(`CIU_OFS_COPROC, 8'h01);
    rd(`CIU_OFS_COPROC, 8'h00);
    // every priority start with a random subset of four pending sources enabled
    for (int p = 0; p < 6; p++)
    begin
      m = $urandom_range(15, 1);
      dly = 2'($urandom_range(3, 0));
      wr(`CIU_OFS_MASK, 8'(m));
      pv = 8'h38;
      dsp_n = 1'b0;
      idle(6);
      pv = 8'h3f;
      dsp_n = 1'b1;
      idle(4);
      check({15'h0, req}, 16'h0000);
      wr(`CIU_OFS_PRIO, 8'(p));
      for (int k = 0; k < 6; k++)
      begin
        s = (p + k) % 6;
        if (s < 4 && m[s])
        begin
          int_q.push_back(3'(s));
          wr(`CIU_OFS_MASK, 8'h80 | 8'(m));
          grant_wait();
        end
      end
      rd(`CIU_OFS_FLAGS, 8'(~m & 15));
      wr(`CIU_OFS_MASK, 8'h00);
      wr(`CIU_OFS_FLAGS, 8'h00);
    end
    // timer a single pass with a random prescale and load
    d = $urandom_range(4, 1);
    l = $urandom_range(4, 2);
    wr(`CIU_OFS_T0PRE, {d[5:0], 2'h0});
    wr(`CIU_OFS_T0CNT, l[7:0]);
    wr(`CIU_OFS_TMODE, 8'h03);
    rd(`CIU_OFS_TMODE, 8'h02);
    idle(l * d * 4 + 30);
    rd(`CIU_OFS_T0CNT, 8'h00);
    rd(`CIU_OFS_TMODE, 8'h00);
    rd(`CIU_OFS_FLAGS, 8'h10);
    rd(`CIU_OFS_T0PRE, 8'h00);
    // timer b continuous, stopped, then resumed
    wr(`CIU_OFS_T1PRE, 8'h05);
    wr(`CIU_OFS_T1CNT, 8'h02);
    wr(`CIU_OFS_TMODE, 8'h0c);
    idle(30);
    rd(`CIU_OFS_TMODE, 8'h08);
    wr(`CIU_OFS_FLAGS, 8'h00);
    idle(20);
    rd(`CIU_OFS_FLAGS, 8'h20);
    wr(`CIU_OFS_TMODE, 8'h00);
    wr(`CIU_OFS_FLAGS, 8'h00);
    idle(40);
    rd(`CIU_OFS_FLAGS, 8'h00);
    wr(`CIU_OFS_TMODE, 8'h08);
    idle(20);
    rd(`CIU_OFS_FLAGS, 8'h20);
    // timer b clocked by pin a rising edges, single pass, divide by one
    wr(`CIU_OFS_TMODE, 8'h00);
    pv = 8'h3e;
    wr(`CIU_OFS_T1PRE, 8'h04);
    wr(`CIU_OFS_T1CNT, 8'h02);
    idle(6);
    wr(`CIU_OFS_FLAGS, 8'h00);
    wr(`CIU_OFS_TMODE, 8'h1c);
    pv = 8'h3f;
    idle(6);
    rd(`CIU_OFS_T1CNT, 8'h01);
    pv = 8'h3e;
    idle(6);
    pv = 8'h3f;
    idle(6);
    rd(`CIU_OFS_FLAGS, 8'h24);
    rd(`CIU_OFS_TMODE, 8'h10);
    // gate mode: a low pin holds the count, a high pin lets the internal clock in
    pv = 8'h3e;
    idle(6);
    wr(`CIU_OFS_FLAGS, 8'h00);
    wr(`CIU_OFS_TMODE, 8'h3c);
    idle(20);
    rd(`CIU_OFS_T1CNT, 8'h02);
    pv = 8'h3f;
    idle(20);
    rd(`CIU_OFS_FLAGS, 8'h20);
    // trigger mode: the counter waits for a pin rise, then runs one pass
    pv = 8'h3e;
    idle(6);
    wr(`CIU_OFS_FLAGS, 8'h00);
    wr(`CIU_OFS_TMODE, 8'h50);
    idle(20);
    rd(`CIU_OFS_FLAGS, 8'h00);
    pv = 8'h3f;
    idle(20);
    rd(`CIU_OFS_FLAGS, 8'h20);
    // cascade: two end pulses of a continuous timer a finish timer b
    wr(`CIU_OFS_T0PRE, 8'h05);
    wr(`CIU_OFS_T0CNT, 8'h01);
    wr(`CIU_OFS_FLAGS, 8'h00);
    wr(`CIU_OFS_TMODE, 8'h8f);
    idle(18);
    rd(`CIU_OFS_FLAGS, 8'h30);
    rd(`CIU_OFS_TMODE, 8'h82);
    wr(`CIU_OFS_TMODE, 8'h00);
    idle(4);
    stop_test();
  end
endmodule

/* common/ciu_pkg.sv */
// types shared by the interrupt/timer unit
package ciu_pkg;
  typedef enum logic [1:0]
  {
    ciu_tin_clock = 2'h0,
    ciu_tin_gate = 2'h1,
    ciu_tin_trig = 2'h2,
    ciu_tin_retrig = 2'h3
  } ciu_tin_mode_t;

  typedef struct packed {
    logic [5:0] pre;
    logic [7:0] cnt;
    logic run;
    logic eoc;
  } ciu_tmr_st_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
    logic dsp_prev;
    logic [5:0] flags;
    logic [1:0] edge_sel;
    logic [7:0] mask;
    logic [2:0] prio;
    logic [1:0][7:0] load;
    logic [1:0][5:0] div;
    logic [1:0] cont;
    logic t1_ext;
    ciu_tin_mode_t tin_mode;
    logic cascade;
    logic [1:0] div4;
    logic req;
    logic [2:0] src;
    logic [7:0] rdata;
  } ciu_st_t;
endpackage

/* common/ciu_regs.svh */
// register offsets, field positions, reset values and counts of the interrupt/timer unit
`ifndef CIU_REGS_SVH
`define CIU_REGS_SVH
`define CIU_OFS_PINS 8'hf0
`define CIU_OFS_TMODE 8'hf1
`define CIU_OFS_T1CNT 8'hf2
`define CIU_OFS_T1PRE 8'hf3
`define CIU_OFS_T0CNT 8'hf4
`define CIU_OFS_T0PRE 8'hf5
`define CIU_OFS_PRIO 8'hf9
`define CIU_OFS_FLAGS 8'hfa
`define CIU_OFS_MASK 8'hfb
`define CIU_OFS_COPROC 8'h0c
`define CIU_NTMR 2
`define CIU_SRC_DSP 3
`define CIU_MASK_GLOBAL 7
`define CIU_COPROC_CLR 0
`define CIU_PRE_CONT 0
`define CIU_TM_RESTART0 0
`define CIU_TM_RUN0 1
`define CIU_TM_RESTART1 2
`define CIU_TM_RUN1 3
`define CIU_TM_EXT 4
`define CIU_PIN_A 0
`define CIU_PIN_B 1
`define CIU_PIN_C 2
`define CIU_PIN_HS0 3
`define CIU_PIN_HS1 4
`define CIU_PIN_HS2 5
`define CIU_PIN_CMP1 6
`define CIU_PIN_CMP2 7
`define CIU_EDGE_BOTH 2'h3
`define CIU_INT_DIV_LAST 2'h3
`define CIU_PRE_FIRE 6'h01
`define CIU_CNT_LAST 8'h01
`define CIU_CNT_ZERO 8'h00
`define CIU_PRIO_LAST 3'h5
`define CIU_VEC_BASE 12'h000
`define CIU_RST_PINS 8'hff
`endif

/* common/ciu_tmr_if.sv */
// control and status bundle between the unit and one counter/timer
`timescale 1ns/100ps
interface ciu_tmr_if;
  logic tick;
  logic restart;
  logic run_wr;
  logic run_val;
  logic cont;
  logic [7:0] load;
  logic [5:0] div;
  logic [7:0] count;
  logic eoc;
  logic running;
  modport ctl (output tick, restart, run_wr, run_val, cont, load, div,
               input count, eoc, running);
  modport tmr (input tick, restart, run_wr, run_val, cont, load, div,
               output count, eoc, running);
endinterface

/* core/ciu_timer.sv */
// one 8-bit down counter with its 6-bit prescaler
`timescale 1ns/100ps
`include "ciu_regs.svh"
module ciu_timer
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  ciu_tmr_if.tmr tp
);
  import ciu_pkg::*;

  ciu_tmr_st_t st_ff;
  ciu_tmr_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler and counter; a zero prescale gives 64, a zero load gives 256
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.eoc = 1'b0;
    if (tp.run_wr)
    begin
      nxt_st.run = tp.run_val; // start, stop or resume
    end
    if (tp.restart)
    begin
      nxt_st.cnt = tp.load; // restart from the initial value
      nxt_st.pre = tp.div;
    end
    else if (st_ff.run && tp.tick)
    begin
      if (st_ff.pre == `CIU_PRE_FIRE)
      begin
        nxt_st.pre = tp.div; // divide by 1 to 64
        if (st_ff.cnt == `CIU_CNT_LAST)
        begin
          nxt_st.eoc = 1'b1; // one-cycle pulse with the reload or stop
          if (tp.cont)
          begin
            nxt_st.cnt = tp.load; // modulo-n reload
          end
          else
          begin
            nxt_st.cnt = `CIU_CNT_ZERO; // single pass halts at zero
            nxt_st.run = 1'b0;
          end
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
      else
      begin
        nxt_st.pre = st_ff.pre - 6'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // count is visible, the prescaler is not
  assign tp.count = st_ff.cnt;
  assign tp.eoc = st_ff.eoc;
  assign tp.running = st_ff.run;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // a run write landing on the end pulse legally overrides the run bit
  a_eoc_reload: assert property (st_ff.eoc && $past(tp.cont) |->
    st_ff.cnt == $past(tp.load) && (st_ff.run || $past(tp.run_wr && !tp.run_val)))
  else $error("continuous timer did not reload with its end pulse");

  a_single_stop: assert property (st_ff.eoc && !$past(tp.cont) |->
    (!st_ff.run || $past(tp.run_wr && tp.run_val)) &&
    st_ff.cnt == `CIU_CNT_ZERO ##1 !st_ff.eoc)
  else $error("single pass timer did not stop at zero");
endmodule

/* core/ciu_top.sv */
// six-source prioritised vectored interrupt unit with two counter/timers
`timescale 1ns/100ps
`include "ciu_regs.svh"
module ciu_top
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic edge_pin_a_i,
  input wire logic edge_pin_b_i,
  input wire logic falling_pin_c_i,
  input wire logic hs0_data_valid_n_i,
  input wire logic hs1_data_valid_n_i,
  input wire logic hs2_data_valid_n_i,
  input wire logic comparator_one_out_i,
  input wire logic comparator_two_out_i,
  input wire logic dsp_req_n_i,
  input wire logic int_ack_i,
  output logic int_req_o,
  output logic [2:0] int_src_o,
  output logic [15:0] int_vec_addr_o
);
  import ciu_pkg::*;

  ciu_st_t st_ff;
  ciu_st_t nxt_st;
  logic [7:0] pin_s;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [5:0] ev;
  logic edge_a;
  logic edge_b;
  logic int_tick;
  logic tm_wr;
  logic trig;
  logic [3:0] pick;
  logic [1:0] tick;
  logic [1:0] restart;
  logic [1:0] run_wr;
  logic [1:0] run_val;
  logic [1:0] t_eoc;
  logic [1:0] t_run;
  logic [1:0][7:0] t_cnt;

  // rotating priority: the programmed source is highest, then upward modulo six
  function automatic logic [3:0] ciu_pick(input logic [5:0] pend, input logic [2:0] first);
    logic [3:0] idx;
    logic [3:0] res;
    logic [2:0] base;
    res = 4'h0;
    base = (first > `CIU_PRIO_LAST) ? 3'h0 : first;
    for (int k = 5; k >= 0; k--)
    begin
      idx = {1'b0, base} + k[3:0];
      if (idx > {1'b0, `CIU_PRIO_LAST})
      begin
        idx = idx - 4'h6;
      end
      if (pend[idx[2:0]])
      begin
        res = {1'b1, idx[2:0]};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection works only on the second synchroniser stage
  assign pin_s = st_ff.s2;
  assign rise = pin_s & ~st_ff.prev;
  assign fall = ~pin_s & st_ff.prev;

  // edge select for pins a and b; both edges when the field is all ones
  always_comb
  begin
    if (st_ff.edge_sel == `CIU_EDGE_BOTH)
    begin
      edge_a = rise[`CIU_PIN_A] | fall[`CIU_PIN_A];
      edge_b = rise[`CIU_PIN_B] | fall[`CIU_PIN_B];
    end
    else
    begin
      edge_a = st_ff.edge_sel[1] ? rise[`CIU_PIN_A] : fall[`CIU_PIN_A];
      edge_b = st_ff.edge_sel[0] ? rise[`CIU_PIN_B] : fall[`CIU_PIN_B];
    end
  end

  // the six request events
  assign ev[0] = fall[`CIU_PIN_HS0] | edge_b | rise[`CIU_PIN_CMP2];
  assign ev[1] = fall[`CIU_PIN_HS1] | fall[`CIU_PIN_C];
  assign ev[2] = fall[`CIU_PIN_HS2] | edge_a | rise[`CIU_PIN_CMP1];
  assign ev[3] = st_ff.dsp_prev & ~dsp_req_n_i; // same-clock source, no sync
  assign ev[5:4] = t_eoc;

  ////////////////////////////////////////////////////////////////////////////////
  // timer clocks: internal clock is the system clock divided by four
  assign int_tick = (st_ff.div4 == `CIU_INT_DIV_LAST);
  assign tm_wr = reg_wr_i && (reg_addr_i == `CIU_OFS_TMODE);

  // timer b input selection; cascade overrides the pin modes
  always_comb
  begin
    tick[0] = int_tick;
    tick[1] = int_tick;
    trig = 1'b0;
    if (st_ff.cascade)
    begin
      tick[1] = t_eoc[0];
    end
    else if (st_ff.t1_ext)
    begin
      unique case (st_ff.tin_mode)
        ciu_tin_clock: tick[1] = rise[`CIU_PIN_A];
        ciu_tin_gate: tick[1] = int_tick & pin_s[`CIU_PIN_A];
        ciu_tin_trig: trig = rise[`CIU_PIN_A] & ~t_run[1];
        ciu_tin_retrig: trig = rise[`CIU_PIN_A];
      endcase
    end
  end

  // run and restart commands from the timer mode register or the trigger
  assign restart[0] = tm_wr & reg_wdata_i[`CIU_TM_RESTART0];
  assign restart[1] = (tm_wr & reg_wdata_i[`CIU_TM_RESTART1]) | trig;
  assign run_wr[0] = tm_wr;
  assign run_wr[1] = tm_wr | trig;
  assign run_val[0] = reg_wdata_i[`CIU_TM_RUN0];
  assign run_val[1] = tm_wr ? reg_wdata_i[`CIU_TM_RUN1] : 1'b1;

  genvar gi;
  for (gi = 0; gi < `CIU_NTMR; gi++)
  begin : g_tmr
    ciu_tmr_if tif ();
    assign tif.tick = tick[gi];
    assign tif.restart = restart[gi];
    assign tif.run_wr = run_wr[gi];
    assign tif.run_val = run_val[gi];
    assign tif.cont = st_ff.cont[gi];
    assign tif.load = st_ff.load[gi];
    assign tif.div = st_ff.div[gi];
    assign t_cnt[gi] = tif.count;
    assign t_eoc[gi] = tif.eoc;
    assign t_run[gi] = tif.running;
    ciu_timer u_tmr
    (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .tp(tif.tmr)
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes, flag update, arbitration and read data
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = {comparator_two_out_i, comparator_one_out_i, hs2_data_valid_n_i,
                 hs1_data_valid_n_i, hs0_data_valid_n_i, falling_pin_c_i,
                 edge_pin_b_i, edge_pin_a_i};
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.s2;
    nxt_st.dsp_prev = dsp_req_n_i;
    nxt_st.div4 = st_ff.div4 + 2'h1;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CIU_OFS_FLAGS: {nxt_st.edge_sel, nxt_st.flags} = reg_wdata_i;
        `CIU_OFS_MASK: nxt_st.mask = reg_wdata_i;
        `CIU_OFS_PRIO: nxt_st.prio = reg_wdata_i[2:0];
        `CIU_OFS_T0CNT: nxt_st.load[0] = reg_wdata_i;
        `CIU_OFS_T1CNT: nxt_st.load[1] = reg_wdata_i;
        `CIU_OFS_T0PRE:
        begin
          nxt_st.div[0] = reg_wdata_i[7:2];
          nxt_st.cont[0] = reg_wdata_i[`CIU_PRE_CONT];
        end
        `CIU_OFS_T1PRE:
        begin
          nxt_st.div[1] = reg_wdata_i[7:2];
          nxt_st.cont[1] = reg_wdata_i[`CIU_PRE_CONT];
        end
        `CIU_OFS_TMODE:
        begin
          nxt_st.t1_ext = reg_wdata_i[`CIU_TM_EXT];
          nxt_st.tin_mode = ciu_tin_mode_t'(reg_wdata_i[6:5]);
          nxt_st.cascade = reg_wdata_i[7];
        end
        default:
        begin
        end
      endcase
    end
    // grant: clear the taken flag and the global enable
    if (int_ack_i && st_ff.req)
    begin
      nxt_st.flags[st_ff.src] = 1'b0;
      nxt_st.mask[`CIU_MASK_GLOBAL] = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == `CIU_OFS_COPROC && reg_wdata_i[`CIU_COPROC_CLR])
    begin
      nxt_st.flags[`CIU_SRC_DSP] = 1'b0;
    end
    // events win over any clear in the same cycle; mask does not gate flags
    nxt_st.flags = nxt_st.flags | ev;
    pick = ciu_pick(nxt_st.flags & nxt_st.mask[5:0], nxt_st.prio);
    nxt_st.req = nxt_st.mask[`CIU_MASK_GLOBAL] & pick[3];
    nxt_st.src = pick[2:0];
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `CIU_OFS_FLAGS: nxt_st.rdata = {st_ff.edge_sel, st_ff.flags};
        `CIU_OFS_MASK: nxt_st.rdata = st_ff.mask;
        `CIU_OFS_PRIO: nxt_st.rdata = {5'h00, st_ff.prio};
        `CIU_OFS_T0CNT: nxt_st.rdata = t_cnt[0];
        `CIU_OFS_T1CNT: nxt_st.rdata = t_cnt[1];
        `CIU_OFS_PINS: nxt_st.rdata = {5'h00, pin_s[2:0]};
        `CIU_OFS_COPROC: nxt_st.rdata = {7'h00, st_ff.flags[`CIU_SRC_DSP]};
        `CIU_OFS_TMODE: nxt_st.rdata = {st_ff.cascade, st_ff.tin_mode, st_ff.t1_ext,
                                        t_run[1], 1'b0, t_run[0], 1'b0};
        default: nxt_st.rdata = 8'h00; // prescalers read as zero
      endcase
    end
  end

  // state register; idle-high reset for the pin history avoids false edges
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
      st_ff.s1 <= `CIU_RST_PINS;
      st_ff.s2 <= `CIU_RST_PINS;
      st_ff.prev <= `CIU_RST_PINS;
      st_ff.dsp_prev <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs all come from the state register
  assign reg_rdata_o = st_ff.rdata;
  assign int_req_o = st_ff.req;
  assign int_src_o = st_ff.src;
  assign int_vec_addr_o = {`CIU_VEC_BASE, st_ff.src, 1'b0};

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  a_masked_no_req: assert property (int_req_o |-> st_ff.mask[`CIU_MASK_GLOBAL] &&
    st_ff.flags[int_src_o] && st_ff.mask[int_src_o])
  else $error("request raised for a masked source");

  a_vector_slot: assert property (int_req_o |->
    int_vec_addr_o == {12'h000, int_src_o, 1'b0} && int_src_o <= 3'h5)
  else $error("vector address not in the source slot");

  a_grant_closes: assert property (int_ack_i && int_req_o |=>
    !int_req_o && !st_ff.mask[`CIU_MASK_GLOBAL])
  else $error("grant did not disable further interrupts");

  a_poll_masked: assert property (t_eoc[1] |=> st_ff.flags[5])
  else $error("timer b event not recorded");

  a_dsp_fall: assert property ($fell(dsp_req_n_i) |=> st_ff.flags[`CIU_SRC_DSP])
  else $error("coprocessor falling edge not latched");

  a_flag_holds: assert property (st_ff.flags[1] && !(int_ack_i && int_req_o &&
    int_src_o == 3'h1) && !(reg_wr_i && reg_addr_i == `CIU_OFS_FLAGS) |=> st_ff.flags[1])
  else $error("request flag dropped without a clear");

  a_dsp_clear: assert property (reg_wr_i && reg_addr_i == `CIU_OFS_COPROC &&
    reg_wdata_i[`CIU_COPROC_CLR] && !ev[3] && dsp_req_n_i |=> !st_ff.flags[`CIU_SRC_DSP])
  else $error("coprocessor request not cleared by write of one");

  a_pin_state: assert property (reg_rd_i && reg_addr_i == `CIU_OFS_PINS |=>
    reg_rdata_o == {5'h00, $past(st_ff.s2[2:0])})
  else $error("pin state read back wrong");
endmodule
